// [rtl/drive_monitor_params.svh]
// Offsets, reset values, selection codes and timing figures of the drive monitor block.
`ifndef DRIVE_MONITOR_PARAMS_SVH
`define DRIVE_MONITOR_PARAMS_SVH
`define CLK_PERIOD_NS 5
`define TICK_MS 100
`define HOUR_S 3600
`define KEY_HOLD_MS 1000
`define ENERGY_LSB_WS 36000
`define HOUR_MAX 16'hFFFF
`define ENERGY_MAX 20'hF423F
`define OFS_PANEL_SEL 8'h00
`define OFS_DECIMAL_SEL 8'h04
`define OFS_POSITION_SEL 8'h08
`define OFS_ENERGY_CLR 8'h0C
`define OFS_RUNTIME_CLR 8'h10
`define OFS_POWER_HOURS 8'h14
`define OFS_RUN_HOURS 8'h18
`define OFS_POWER_WRAP 8'h1C
`define OFS_RUN_WRAP 8'h20
`define OFS_ENERGY 8'h24
`define OFS_PANEL_STATE 8'h28
`define OFS_POWERON_POS 8'h2C
`define SEL_DEFAULT 8'h00
`define SEL_POWER_HOURS 8'h14
`define SEL_RUN_HOURS 8'h17
`define SEL_ENERGY 8'h19
`define SEL_TERMINALS 8'h37
`define SEL_THERMAL 8'h07
`define SEL_SET_SPEED 8'h64
`define SETTING_NONE 14'h270F
`define SETTING_ZERO 14'h0000
`define SETTING_ONE 14'h0001
`define SETTING_TEN 14'h000A
`define DISPLAY_MAX 14'h270F
`define DP_SPEED 2'h0
`define DP_CURRENT 2'h2
`define DP_VOLTAGE 2'h1
`define DP_THERMAL 2'h1
`define DP_HOURS 2'h2
`endif

// [rtl/drive_monitor_pkg.sv]
// Types shared by the drive monitor block and its bench.
package drive_monitor_pkg;
  typedef enum logic [3:0] {
    POS_FIRST = 4'h1,
    POS_SECOND = 4'h2,
    POS_THIRD = 4'h4,
    POS_FAULT = 4'h8
  } panel_pos_t;

  typedef struct packed {
    logic [15:0] speed;
    logic [15:0] set_speed;
    logic [15:0] current;
    logic [15:0] voltage;
    logic [15:0] motor_thermal;
    logic [15:0] drive_thermal;
    logic [15:0] power_w;
    logic [31:0] position;
  } monitor_t;

  typedef struct packed {
    logic [13:0] value;
    logic [1:0] decimals;
    logic dashes;
    logic hz_led;
    logic terminal_view;
  } panel_t;
endpackage

// [rtl/drive_monitor.sv]
// Monitor accumulators, panel selection and APB register slave of the drive unit.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "drive_monitor_params.svh"

// Notes on behaviour
// - Energization and run hour counts go 0 to 65535, then restart at 0.
// - Panel shows hours at 1h = 0.001, up to 65.53, then restarts.
// - A run hour is only added after one full hour of running.
// - Values above 9999 are shown as four dashes.
// - Combined thermal view shows the larger of motor and transistor thermal.
// - Monitored values are held on a fault and cleared by reset or fault reset.
// - With selection 0 the set key steps speed, current, voltage, fault.
// - The selected monitor appears in the third panel position; selection 100 uses the first.
// - First monitor at power-on; one-second set key hold makes current view power-on view.
// - Selection 100 shows set speed while stopped; Hz LED blinks stopped, lit running.
// - Error shows captured values; output shutoff displays as when stopped.
// - Selection 55 shows terminals on LEDs; inputs upper, outputs lower, centre lit.
// - Output power is added every 100 ms; energy is saved hourly.
// - Energy shows 0.01 kWh steps to 99.99, then 0.1 kWh, then 1 kWh.
// - Writing zero clears energy; the setting then reads 9999.
// - Selection 20 shows energization time in 10-hour steps.
// - Selection 23 shows running time counted only while running.
// - Separate wrap counts for energization and running hour counters.
// - Zero clears running hours only; 9999 clears nothing; setting reads 9999.
// - Decimal 9999 unchanged, 0 truncates to integer, 1 drops hundredths.
// - Decimal selection does not touch hour and energy views.
// - Position view replaces speed in the first position, unsigned.
module drive_monitor #(
  parameter int TICK_CYCLES = (`TICK_MS * 1000000) / `CLK_PERIOD_NS,
  parameter int HOUR_TICKS = (`HOUR_S * 1000) / `TICK_MS,
  parameter int IN_TERMS = 7,
  parameter int OUT_TERMS = 7
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire drive_monitor_pkg::monitor_t monitor_in,
  input wire logic running_in,
  input wire logic fault_in,
  input wire logic fault_reset_in,
  input wire logic output_shutoff_input_in,
  input wire logic [7:0] fault_code_in,
  input wire logic key_set_in,
  input wire logic [IN_TERMS-1:0] input_terms_in,
  input wire logic [OUT_TERMS-1:0] output_terms_in,
  output drive_monitor_pkg::panel_t panel_out,
  output logic [IN_TERMS+OUT_TERMS:0] term_led_out,
  output logic nvm_save_out
);
  localparam int ENERGY_CARRY = (`ENERGY_LSB_WS * 1000) / `TICK_MS;
  localparam int KEY_HOLD_TICKS = `KEY_HOLD_MS / `TICK_MS;

  logic [31:0] prescale;
  logic tick;
  logic [31:0] power_sub;
  logic [31:0] run_sub;
  logic hour_tick;
  logic [15:0] power_hours;
  logic [15:0] run_hours;
  logic [15:0] power_wrap;
  logic [15:0] run_wrap;
  logic [19:0] energy;
  logic [18:0] energy_frac;
  logic [7:0] panel_monitor_select;
  logic [13:0] decimal_digit_select;
  logic [1:0] position_view_select;
  logic [13:0] energy_total_clear;
  drive_monitor_pkg::panel_pos_t pos;
  drive_monitor_pkg::panel_pos_t poweron_pos;
  drive_monitor_pkg::monitor_t held;
  logic key_prev;
  logic [7:0] hold_cnt;
  logic blink;
  logic wr;
  logic energy_clear;
  logic runtime_clear;
  logic stopped;
  drive_monitor_pkg::monitor_t mon;
  drive_monitor_pkg::panel_t next_panel;
  logic [31:0] sel_value;
  logic [1:0] sel_dp;
  logic sel_raw;
  logic [31:0] pos_abs;
  logic [31:0] fmt_value;
  logic [1:0] fmt_dp;
  logic [31:0] next_rdata;
  logic next_err;

  assign wr = psel_in & penable_in & pwrite_in;
  assign energy_clear = wr && paddr_in == `OFS_ENERGY_CLR && pwdata_in[13:0] == `SETTING_ZERO;
  assign runtime_clear = wr && paddr_in == `OFS_RUNTIME_CLR && pwdata_in[13:0] == `SETTING_ZERO;
  assign stopped = ~running_in | output_shutoff_input_in;
  assign mon = fault_in ? held : monitor_in;

  // Base tick prescaler; everything slow is counted in these 100 ms ticks.
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      prescale <= 32'h0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= prescale == 32'(TICK_CYCLES - 1);
      prescale <= (prescale == 32'(TICK_CYCLES - 1)) ? 32'h0 : prescale + 32'h1;
    end
  end

  // Energization hours: a partial hour is lost at power-off, by design.
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      power_sub <= 32'h0;
      hour_tick <= 1'b0;
      power_hours <= 16'h0;
      power_wrap <= 16'h0;
    end
    else
    begin
      hour_tick <= 1'b0;
      if (tick)
      begin
        power_sub <= (power_sub == 32'(HOUR_TICKS - 1)) ? 32'h0 : power_sub + 32'h1;
        if (power_sub == 32'(HOUR_TICKS - 1))
        begin
          hour_tick <= 1'b1;
          power_hours <= power_hours + 16'h1;
          if (power_hours == `HOUR_MAX)
            power_wrap <= power_wrap + 16'h1;
        end
      end
    end
  end

  // Running hours only advance on ticks spent running.
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      run_sub <= 32'h0;
      run_hours <= 16'h0;
      run_wrap <= 16'h0;
    end
    else if (runtime_clear)
    begin
      run_hours <= 16'h0;
      run_sub <= 32'h0;
    end
    else if (tick && running_in)
    begin
      run_sub <= (run_sub == 32'(HOUR_TICKS - 1)) ? 32'h0 : run_sub + 32'h1;
      if (run_sub == 32'(HOUR_TICKS - 1))
      begin
        run_hours <= run_hours + 16'h1;
        if (run_hours == `HOUR_MAX)
          run_wrap <= run_wrap + 16'h1;
      end
    end
  end

  // Energy in 0.01 kWh, fed by power in watts; a single carry suffices since power stays below the carry.
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in || energy_clear)
    begin
      energy <= 20'h0;
      energy_frac <= 19'h0;
    end
    else if (tick)
    begin
      if ({3'h0, energy_frac} + {16'h0, mon.power_w} >= 35'(ENERGY_CARRY))
      begin
        energy_frac <= 19'({3'h0, energy_frac} + {16'h0, mon.power_w} - 35'(ENERGY_CARRY));
        if (energy != `ENERGY_MAX)
          energy <= energy + 20'h1;
      end
      else
        energy_frac <= energy_frac + 19'(mon.power_w);
    end
  end

  // Hourly save strobe towards the nonvolatile store.
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
      nvm_save_out <= 1'b0;
    else
      nvm_save_out <= hour_tick;
  end

  // Snapshot follows the live values until a fault freezes it; fault reset clears it.
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in || fault_reset_in)
      held <= '0;
    else if (!fault_in)
      held <= monitor_in;
  end

  // Software settings.
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      panel_monitor_select <= `SEL_DEFAULT;
      decimal_digit_select <= `SETTING_NONE;
      position_view_select <= 2'h0;
      energy_total_clear <= `SETTING_NONE;
    end
    else if (wr)
    begin
      unique case (paddr_in)
        `OFS_PANEL_SEL: panel_monitor_select <= pwdata_in[7:0];
        `OFS_DECIMAL_SEL: decimal_digit_select <= pwdata_in[13:0];
        `OFS_POSITION_SEL: position_view_select <= pwdata_in[1:0];
        // Zero is an action, not a value to keep, so it never reads back.
        `OFS_ENERGY_CLR: energy_total_clear <= (pwdata_in[13:0] == `SETTING_TEN) ? `SETTING_TEN : `SETTING_NONE;
        default: ;
      endcase
    end
  end

  // Set key: press steps the view, a one-second hold stores it as the power-on view.
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      key_prev <= 1'b0;
      hold_cnt <= 8'h0;
      pos <= drive_monitor_pkg::POS_FIRST;
      poweron_pos <= drive_monitor_pkg::POS_FIRST;
    end
    else
    begin
      key_prev <= key_set_in;
      if (!key_set_in)
        hold_cnt <= 8'h0;
      else if (tick && hold_cnt != 8'hFF)
        hold_cnt <= hold_cnt + 8'h1;
      if (key_set_in && tick && hold_cnt == 8'(KEY_HOLD_TICKS - 1))
        poweron_pos <= pos;
      if (wr && paddr_in == `OFS_POWERON_POS)
        pos <= drive_monitor_pkg::panel_pos_t'(pwdata_in[3:0]);
      else if (key_set_in && !key_prev)
      begin
        unique case (pos)
          drive_monitor_pkg::POS_FIRST: pos <= drive_monitor_pkg::POS_SECOND;
          drive_monitor_pkg::POS_SECOND: pos <= drive_monitor_pkg::POS_THIRD;
          drive_monitor_pkg::POS_THIRD: pos <= drive_monitor_pkg::POS_FAULT;
          drive_monitor_pkg::POS_FAULT: pos <= drive_monitor_pkg::POS_FIRST;
          default: pos <= drive_monitor_pkg::POS_FIRST;
        endcase
      end
    end
  end

  // Blink phase for the Hz LED while stopped.
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
      blink <= 1'b0;
    else if (tick)
      blink <= ~blink;
  end

  // Pick the raw value for the current panel position.
  always_comb
  begin
    pos_abs = mon.position[31] ? 32'(-mon.position) : mon.position;
    sel_value = {16'h0, mon.speed};
    sel_dp = `DP_SPEED;
    sel_raw = 1'b0;
    unique case (pos)
      drive_monitor_pkg::POS_FIRST:
      begin
        if (position_view_select == 2'h1)
          sel_value = pos_abs % 32'd10000;
        else if (position_view_select == 2'h2)
          sel_value = pos_abs / 32'd10000;
        else if (panel_monitor_select == `SEL_SET_SPEED && stopped)
          sel_value = {16'h0, mon.set_speed};
      end
      drive_monitor_pkg::POS_SECOND:
      begin
        sel_value = {16'h0, mon.current};
        sel_dp = `DP_CURRENT;
      end
      drive_monitor_pkg::POS_THIRD:
      begin
        sel_value = {16'h0, mon.voltage};
        sel_dp = `DP_VOLTAGE;
        unique case (panel_monitor_select)
          `SEL_POWER_HOURS:
          begin
            sel_value = {16'h0, power_hours} / 32'd10;
            sel_dp = `DP_HOURS;
            sel_raw = 1'b1;
          end
          `SEL_RUN_HOURS:
          begin
            sel_value = {16'h0, run_hours} / 32'd10;
            sel_dp = `DP_HOURS;
            sel_raw = 1'b1;
          end
          `SEL_ENERGY:
          begin
            sel_raw = 1'b1;
            sel_value = {12'h0, energy};
            sel_dp = 2'h2;
            if (energy >= 20'd100000)
            begin
              sel_value = {12'h0, energy} / 32'd100;
              sel_dp = 2'h0;
            end
            else if (energy >= 20'd10000)
            begin
              sel_value = {12'h0, energy} / 32'd10;
              sel_dp = 2'h1;
            end
          end
          `SEL_THERMAL:
          begin
            sel_value = {16'h0, (mon.motor_thermal > mon.drive_thermal) ? mon.motor_thermal : mon.drive_thermal};
            sel_dp = `DP_THERMAL;
          end
          default: ;
        endcase
      end
      drive_monitor_pkg::POS_FAULT: sel_value = {24'h0, fault_code_in};
      default: ;
    endcase
  end

  // Decimal selection, then the four-digit limit.
  always_comb
  begin
    fmt_value = sel_value;
    fmt_dp = sel_dp;
    if (!sel_raw && decimal_digit_select == `SETTING_ZERO)
    begin
      // Truncation keeps anything below one unit at zero.
      fmt_value = (sel_dp == 2'h2) ? sel_value / 32'd100 : (sel_dp == 2'h1) ? sel_value / 32'd10 : sel_value;
      fmt_dp = 2'h0;
    end
    else if (!sel_raw && decimal_digit_select == `SETTING_ONE && sel_dp == 2'h2)
    begin
      fmt_value = sel_value / 32'd10;
      fmt_dp = 2'h1;
    end
    next_panel.dashes = fmt_value > {18'h0, `DISPLAY_MAX};
    next_panel.value = next_panel.dashes ? 14'h0 : fmt_value[13:0];
    next_panel.decimals = fmt_dp;
    next_panel.hz_led = (panel_monitor_select == `SEL_SET_SPEED && stopped) ? blink : 1'b1;
    next_panel.terminal_view = pos == drive_monitor_pkg::POS_THIRD && panel_monitor_select == `SEL_TERMINALS;
  end

  // Panel outputs registered so the display sees clean levels.
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      panel_out <= '0;
      term_led_out <= '0;
    end
    else
    begin
      panel_out <= next_panel;
      term_led_out <= next_panel.terminal_view ? {input_terms_in, 1'b1, output_terms_in} : '0;
    end
  end

  // Read mux and error decode, evaluated in the setup cycle.
  always_comb
  begin
    next_rdata = 32'h0;
    next_err = 1'b0;
    unique case (paddr_in)
      `OFS_PANEL_SEL: next_rdata = {24'h0, panel_monitor_select};
      `OFS_DECIMAL_SEL: next_rdata = {18'h0, decimal_digit_select};
      `OFS_POSITION_SEL: next_rdata = {30'h0, position_view_select};
      `OFS_ENERGY_CLR: next_rdata = {18'h0, energy_total_clear};
      `OFS_RUNTIME_CLR: next_rdata = {18'h0, `SETTING_NONE};
      `OFS_POWER_HOURS: next_rdata = {16'h0, power_hours};
      `OFS_RUN_HOURS: next_rdata = {16'h0, run_hours};
      `OFS_POWER_WRAP: next_rdata = {16'h0, power_wrap};
      `OFS_RUN_WRAP: next_rdata = {16'h0, run_wrap};
      `OFS_ENERGY: next_rdata = {12'h0, energy};
      `OFS_PANEL_STATE: next_rdata = {9'h0, next_panel, pos};
      `OFS_POWERON_POS: next_rdata = {28'h0, poweron_pos};
      default: next_err = 1'b1;
    endcase
  end

  // Zero-wait APB slave: data and error are ready by the access phase.
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      prdata_out <= 32'h0;
      pslverr_out <= 1'b0;
      pready_out <= 1'b0;
    end
    else
    begin
      pready_out <= 1'b1;
      if (psel_in && !penable_in)
      begin
        prdata_out <= pwrite_in ? 32'h0 : next_rdata;
        pslverr_out <= next_err;
      end
    end
  end
endmodule // drive_monitor

// [bench/drive_monitor_props.sv]
// Concurrent checks on the ports of the drive monitor block.
`timescale 1ns/10ps
module drive_monitor_props #(
  parameter int TICK_CYCLES = 4,
  parameter int HOUR_TICKS = 3,
  parameter int IN_TERMS = 7,
  parameter int OUT_TERMS = 7
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire drive_monitor_pkg::panel_t panel_out,
  input wire logic [IN_TERMS+OUT_TERMS:0] term_led_out,
  input wire logic nvm_save_out
);
  localparam int HOUR_CYC = TICK_CYCLES * HOUR_TICKS;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // A setup cycle is where the slave loads read data and the error flag.
  wire setup = psel_in && !penable_in;
  property p_ready; $past(resetn_in) |-> pready_out; endproperty
  a_ready: assert property (p_ready) else $error("pready low after reset");
  property p_slverr; setup && paddr_in > 8'h2C |=> pslverr_out; endproperty
  a_slverr: assert property (p_slverr) else $error("no error on unmapped offset");
  property p_okay; setup && paddr_in <= 8'h2C && paddr_in[1:0] == 2'h0 |=> !pslverr_out; endproperty
  a_okay: assert property (p_okay) else $error("error on mapped offset");
  property p_hold; !setup |=> $stable(prdata_out); endproperty
  a_hold: assert property (p_hold) else $error("read data moved outside setup");
  property p_runclr; setup && !pwrite_in && paddr_in == 8'h10 |=> prdata_out == 32'h270F; endproperty
  a_runclr: assert property (p_runclr) else $error("runtime clear setting misread");
  property p_enclr; setup && !pwrite_in && paddr_in == 8'h0C |=> prdata_out inside {32'h270F, 32'h000A}; endproperty
  a_enclr: assert property (p_enclr) else $error("energy clear setting misread");
  property p_centre; panel_out.terminal_view |-> term_led_out[OUT_TERMS]; endproperty
  a_centre: assert property (p_centre) else $error("centre line dark");
  property p_dark; !panel_out.terminal_view |-> term_led_out == '0; endproperty
  a_dark: assert property (p_dark) else $error("terminal leds lit outside view");
  property p_nvm; nvm_save_out |=> !nvm_save_out [*8]; endproperty
  a_nvm: assert property (p_nvm) else $error("save pulse too long");
  property p_hour; nvm_save_out |-> ##HOUR_CYC nvm_save_out; endproperty
  a_hour: assert property (p_hour) else $error("save not hourly");
endmodule // drive_monitor_props

// [bench/panel_operator.sv]
// Operator model that presses the panel set key.
`timescale 1ns/10ps
module panel_operator (
  input wire logic clk_in,
  output logic key_out
);
  initial key_out = 1'b0;
  // Holds the key for a chosen span; a long hold stores the power-on view.
  task automatic press(input int hold);
    @(posedge clk_in);
    key_out <= 1'b1;
    repeat (hold) @(posedge clk_in);
    key_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
endmodule // panel_operator

// [bench/drive_monitor_test.sv]
// Self-checking bench of the drive monitor block.
`timescale 1ns/10ps
`include "drive_monitor_params.svh"
module drive_monitor_test;
  typedef struct {logic [31:0] e; logic [31:0] m;} note_t;
  localparam logic [31:0] PM = 32'h007FFFC0;
  logic mclk = 0, resetn = 0, psel = 0, pen = 0, pwr = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, nvm, key;
  logic running = 1, fault = 0, frst = 0, shut = 0;
  logic [7:0] fcode = '0;
  logic [6:0] tin = '0, tout = '0;
  logic [14:0] leds;
  drive_monitor_pkg::monitor_t mon = '0;
  drive_monitor_pkg::panel_t panel;
  note_t q[$];
  int n_fail = 0, n_compared = 0, cyc = 0;
  drive_monitor #(.TICK_CYCLES(4), .HOUR_TICKS(3)) drive_monitor_inst (.mclk_in(mclk), .resetn_in(resetn),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .monitor_in(mon),
    .running_in(running), .fault_in(fault), .fault_reset_in(frst), .output_shutoff_input_in(shut),
    .fault_code_in(fcode), .key_set_in(key), .input_terms_in(tin), .output_terms_in(tout),
    .panel_out(panel), .term_led_out(leds), .nvm_save_out(nvm));
  panel_operator op (.clk_in(mclk), .key_out(key));
  always #2.5 mclk = ~mclk;
  // Cycle count since release gives the expected hour and energy figures.
  always @(posedge mclk) cyc <= resetn ? cyc + 1 : 0;
  task automatic tally_and_finish;
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request stands until pready is seen high.
  // Only the watchdog ends a wait for pready, so a hung slave is counted as a failure.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    pen <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 0; pen <= 0;
    @(posedge mclk);
  endtask
  // Writes get a few cycles so the registered panel settles before a read.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
    repeat (3) @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    q.push_back('{e, m});
    apb(0, a, 32'h0);
  endtask
  task automatic sync(input int p, input int ph);
    while (cyc % p != ph) @(posedge mclk);
  endtask
  function automatic logic [31:0] pv(input logic [13:0] v, input logic [1:0] dp, input logic d);
    return {9'h0, v, dp, d, 6'h0};
  endfunction
  // Read data is judged at the access edge against the oldest note.
  always @(posedge mclk)
    if (psel && pen && !pwr && pready === 1'b1)
    begin
      note_t n;
      n = q.pop_front();
      cmp(prdata & n.m, n.e & n.m);
    end
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    int t1, t2, th;
    logic [3:0] steps [5];
    steps = '{4'h2, 4'h4, 4'h8, 4'h1, 4'h2};
    void'($urandom(32'h6B2E438B));
    mon.power_w <= 16'h8CA0;
    repeat (20) @(posedge mclk);
    resetn <= 1;
    @(posedge mclk);
    rd(8'h04, 32'h270F);
    rd(8'h0C, 32'h270F);
    rd(8'h10, 32'h270F);
    rd(8'h30, 32'h0);
    rd(8'h28, 32'h1, 32'hF);
    repeat (60) @(posedge mclk);
    sync(12, 4);
    rd(8'h14, cyc / 12);
    rd(8'h18, cyc / 12);
    sync(40, 20);
    rd(8'h24, cyc / 40);
    wr(8'h0C, 32'h0);
    rd(8'h24, 32'h0);
    rd(8'h0C, 32'h270F);
    wr(8'h0C, 32'hA);
    rd(8'h0C, 32'hA);
    running <= 0;
    wr(8'h10, 32'h0);
    repeat (36) @(posedge mclk);
    sync(12, 4);
    rd(8'h18, 32'h0);
    rd(8'h14, cyc / 12);
    t1 = $urandom_range(9999);
    t2 = $urandom_range(9999);
    th = t1 > t2 ? t1 : t2;
    mon.motor_thermal <= 16'(t1);
    mon.drive_thermal <= 16'(t2);
    wr(8'h2C, 32'h4);
    wr(8'h00, `SEL_THERMAL);
    rd(8'h28, pv(14'(th), `DP_THERMAL, 0), PM);
    wr(8'h04, 32'h0);
    rd(8'h28, pv(14'(th / 10), 2'h0, 0), PM);
    wr(8'h04, 32'h1);
    rd(8'h28, pv(14'(th), `DP_THERMAL, 0), PM);
    mon.motor_thermal <= 16'h3039;
    repeat (4) @(posedge mclk);
    rd(8'h28, 32'h40, 32'h40);
    wr(8'h00, `SEL_POWER_HOURS);
    wr(8'h04, 32'h0);
    rd(8'h28, 32'h100, 32'h180);
    sync(12, 4);
    rd(8'h28, pv(14'(cyc / 120), `DP_HOURS, 0), PM);
    wr(8'h00, `SEL_ENERGY);
    rd(8'h28, 32'h100, 32'h180);
    tin <= 7'($urandom);
    tout <= 7'($urandom);
    wr(8'h00, `SEL_TERMINALS);
    cmp(32'(leds), 32'({tin, 1'b1, tout}));
    rd(8'h28, 32'h10, 32'h10);
    fcode <= 8'($urandom);
    wr(8'h00, 32'h0);
    wr(8'h2C, 32'h1);
    for (int i = 0; i < 5; i++)
    begin
      op.press(2);
      rd(8'h28, 32'(steps[i]), 32'hF);
      if (i == 2)
        rd(8'h28, pv(14'(fcode), 2'h0, 0), PM);
    end
    // The press that starts the hold also steps the view, so the third position is stored.
    op.press(50);
    rd(8'h2C, 32'h4);
    wr(8'h2C, 32'h1);
    wr(8'h04, 32'h270F);
    mon.set_speed <= 16'h04D2;
    mon.speed <= 16'h0309;
    wr(8'h00, `SEL_SET_SPEED);
    rd(8'h28, pv(14'h04D2, 2'h0, 0), PM);
    running <= 1;
    repeat (4) @(posedge mclk);
    rd(8'h28, pv(14'h0309, 2'h0, 0) | 32'h20, PM | 32'h20);
    shut <= 1;
    repeat (4) @(posedge mclk);
    rd(8'h28, pv(14'h04D2, 2'h0, 0), PM);
    shut <= 0;
    fault <= 1;
    repeat (4) @(posedge mclk);
    mon.speed <= 16'h022B;
    repeat (4) @(posedge mclk);
    rd(8'h28, pv(14'h0309, 2'h0, 0), PM);
    fault <= 0;
    frst <= 1;
    @(posedge mclk);
    frst <= 0;
    rd(8'h28, pv(14'h022B, 2'h0, 0), PM);
    mon.position <= -32'sd1234567;
    wr(8'h08, 32'h1);
    rd(8'h28, pv(14'h11D7, 2'h0, 0), PM);
    wr(8'h08, 32'h2);
    rd(8'h28, pv(14'h007B, 2'h0, 0), PM);
    tally_and_finish();
  end
endmodule // drive_monitor_test
bind drive_monitor drive_monitor_props #(.TICK_CYCLES(TICK_CYCLES), .HOUR_TICKS(HOUR_TICKS),
  .IN_TERMS(IN_TERMS), .OUT_TERMS(OUT_TERMS)) drive_monitor_props_inst (.mclk_in(mclk_in),
  .resetn_in(resetn_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .panel_out(panel_out), .term_led_out(term_led_out), .nvm_save_out(nvm_save_out));
